// ### core/serial_core.sv
/*
 Serial transceiver core: clock regime selection, shared data register with
 transmit holding buffer and two-entry receive FIFO, status flags and their
 interrupt requests. Assumes a CPU-side I/O access port on the same clock,
 and the clock pin direction supplied by the port logic on the same clock.
*/
`timescale 1ns/100ps
`include "serial_defines.svh"
module serial_core #(
   parameter logic [15:0] BAUD_DIV = `BAUD_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // CPU I/O access
   input  wire logic [1:0] i_io_addr,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_wdata,
   output logic [7:0]      o_io_rdata,
   // Clock pin direction from port logic, high for output
   input  wire logic       i_sck_dir,
   // Interrupt requests and service acknowledge
   output logic            o_rxc_irq,
   output logic            o_txc_irq,
   output logic            o_udre_irq,
   input  wire logic       i_txc_irq_ack,
   // Serial pins
   input  wire logic       i_rxd,
   output logic            o_txd,
   input  wire logic       i_sck_i,
   output logic            o_sck_o,
   output logic            o_sck_oe
);
   logic [7:0]  ctrl_q;
   logic        u2x_q;
   logic        mpcm_q;
   logic [7:0]  rdata_q;
   logic [2:0]  rxd_sync_q;
   logic [2:0]  sck_sync_q;
   logic        rxd_q;
   logic        sck_in_q;
   logic        sck_prev_q;
   logic [15:0] baud_cnt_q;
   logic        sck_q;
   logic [7:0]  txb_q;
   logic        txb_full_q;
   logic [7:0]  tx_sh_q;
   logic [2:0]  tx_bit_q;
   logic        txd_q;
   logic        txc_q;
   logic [15:0] rx_cnt_q;
   logic [7:0]  rx_sh_q;
   logic [2:0]  rx_bit_q;
   logic        rx_pend_q;
   logic [7:0]  rx_char_q;
   serial_pkg::tx_state_e tx_st_q;
   serial_pkg::rx_state_e rx_st_q;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [7:0]  fifo_out_data;

   // Register decode
   wire wr_data = i_io_wr & (i_io_addr == `ADDR_DATA);
   wire rd_data = i_io_rd & (i_io_addr == `ADDR_DATA);
   wire wr_stat = i_io_wr & (i_io_addr == `ADDR_STAT_A);
   wire wr_ctl  = i_io_wr & (i_io_addr == `ADDR_CTRL);

   // Control fields
   wire       rx_en   = ctrl_q[`CTL_RX_EN];
   wire       tx_en   = ctrl_q[`CTL_TX_EN];
   wire       sync    = ctrl_q[`CTL_SYNC_SEL];
   wire [1:0] csz     = ctrl_q[`CTL_SIZE_LO +: 2];
   wire       master  = sync & i_sck_dir;
   wire       slave   = sync & ~i_sck_dir;
   wire [2:0] last_ix = 3'h4 + {1'b0, csz};
   wire [7:0] mask    = 8'hff >> (2'h3 - csz);

   // Clock regime: halve the bit period only when asynchronous
   wire [15:0] div_eff = (u2x_q & ~sync) ? (BAUD_DIV >> 1) : BAUD_DIV;
   wire        tick    = (baud_cnt_q == 16'h0000);

   // Serial clock edges; none at all in asynchronous modes
   wire sck_rise = master ? (tick & ~sck_q) : (slave & sck_in_q & ~sck_prev_q);
   wire sck_fall = master ? (tick & sck_q) : (slave & ~sck_in_q & sck_prev_q);
   wire tx_step  = sync ? sck_fall : tick;
   wire rx_samp  = sync ? sck_rise : (rx_cnt_q == 16'h0000);

   // Transmit path terms
   wire udre     = ~txb_full_q;
   wire txb_take = wr_data & udre;
   wire tx_load  = tx_en & txb_full_q & (tx_st_q == serial_pkg::TX_IDLE);
   wire tx_done  = tx_step & (tx_st_q == serial_pkg::TX_LAST);
   wire txc_set  = tx_done & ~txb_full_q;
   wire txc_clr  = i_txc_irq_ack | (wr_stat & i_io_wdata[`STA_TXC]);

   // Receive path terms
   wire rxc      = fifo_out_valid;
   wire rx_start = rx_en & ~rx_pend_q & ~rxd_q & (~sync | sck_rise);
   wire rx_push  = rx_pend_q & fifo_in_ready;

   // Pins and interrupt requests
   assign o_txd      = txd_q;
   assign o_sck_o    = sck_q;
   assign o_sck_oe   = master;
   assign o_io_rdata = rdata_q;
   assign o_rxc_irq  = rxc & ctrl_q[`CTL_RXC_IE];
   assign o_txc_irq  = txc_q & ctrl_q[`CTL_TXC_IE];
   assign o_udre_irq = udre & ctrl_q[`CTL_UDRE_IE];

   // Software registers and registered read data
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q  <= `CTRL_RESET;
         u2x_q   <= 1'b0;
         mpcm_q  <= 1'b0;
         rdata_q <= `DATA_RESET;
      end else begin
         if (wr_ctl) begin
            ctrl_q <= i_io_wdata;
         end
         if (wr_stat) begin
            u2x_q  <= i_io_wdata[`STA_U2X];
            mpcm_q <= i_io_wdata[`STA_MPCM];
         end
         if (rd_data) begin
            rdata_q <= fifo_out_data;
         end else if (i_io_rd & (i_io_addr == `ADDR_STAT_A)) begin
            rdata_q <= {rxc, txc_q, udre, 3'h0, u2x_q, mpcm_q};
         end else if (i_io_rd & (i_io_addr == `ADDR_CTRL)) begin
            rdata_q <= ctrl_q;
         end else if (i_io_rd) begin
            rdata_q <= 8'h00;
         end
      end
   end

   // Pin synchronisers: a level counts once the second and third flops agree
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rxd_sync_q <= 3'h7;
         sck_sync_q <= 3'h0;
         rxd_q      <= 1'b1;
         sck_in_q   <= 1'b0;
         sck_prev_q <= 1'b0;
      end else begin
         rxd_sync_q <= {rxd_sync_q[1:0], i_rxd};
         sck_sync_q <= {sck_sync_q[1:0], i_sck_i};
         if (rxd_sync_q[1] == rxd_sync_q[2]) begin
            rxd_q <= rxd_sync_q[2];
         end
         if (sck_sync_q[1] == sck_sync_q[2]) begin
            sck_in_q <= sck_sync_q[2];
         end
         sck_prev_q <= sck_in_q;
      end
   end

   // Bit-rate divider; in master mode it also toggles the clock pin
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         baud_cnt_q <= 16'h0000;
         sck_q      <= 1'b0;
      end else begin
         baud_cnt_q <= tick ? (div_eff - 16'h0001) : (baud_cnt_q - 16'h0001);
         if (!master) begin
            sck_q <= 1'b0;
         end else if (tick) begin
            sck_q <= ~sck_q;
         end
      end
   end

   // Transmit holding buffer and complete flag; set wins over clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         txb_q      <= `DATA_RESET;
         txb_full_q <= 1'b0;
         txc_q      <= 1'b0;
      end else begin
         if (txb_take) begin
            txb_q      <= i_io_wdata;
            txb_full_q <= 1'b1;
         end else if (tx_load) begin
            txb_full_q <= 1'b0;
         end
         txc_q <= txc_set | (txc_q & ~txc_clr);
      end
   end

   // Transmit sequencer: start, data LSB first, stop, then frame end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_st_q  <= serial_pkg::TX_IDLE;
         tx_sh_q  <= `DATA_RESET;
         tx_bit_q <= 3'h0;
         txd_q    <= 1'b1;
      end else begin
         unique case (tx_st_q)
            serial_pkg::TX_IDLE: begin
               if (tx_load) begin
                  tx_sh_q <= txb_q & mask;
                  tx_st_q <= serial_pkg::TX_START;
               end
            end
            serial_pkg::TX_START: begin
               if (tx_step) begin
                  txd_q    <= 1'b0;
                  tx_bit_q <= 3'h0;
                  tx_st_q  <= serial_pkg::TX_DATA;
               end
            end
            serial_pkg::TX_DATA: begin
               if (tx_step) begin
                  txd_q    <= tx_sh_q[tx_bit_q];
                  tx_bit_q <= tx_bit_q + 3'h1;
                  if (tx_bit_q == last_ix) begin
                     tx_st_q <= serial_pkg::TX_STOP;
                  end
               end
            end
            serial_pkg::TX_STOP: begin
               if (tx_step) begin
                  txd_q   <= 1'b1;
                  tx_st_q <= serial_pkg::TX_LAST;
               end
            end
            serial_pkg::TX_LAST: begin
               if (tx_step) begin
                  tx_st_q <= serial_pkg::TX_IDLE;
               end
            end
         endcase
      end
   end

   // Receive sequencer; a finished character waits here while the FIFO is
   // full, and no new frame is started until it moves on
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_st_q   <= serial_pkg::RX_IDLE;
         rx_cnt_q  <= 16'h0000;
         rx_sh_q   <= `DATA_RESET;
         rx_bit_q  <= 3'h0;
         rx_pend_q <= 1'b0;
         rx_char_q <= `DATA_RESET;
      end else if (!rx_en) begin
         rx_st_q   <= serial_pkg::RX_IDLE;
         rx_pend_q <= 1'b0;
      end else begin
         if (rx_push) begin
            rx_pend_q <= 1'b0;
         end
         if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
         end else if (rx_st_q != serial_pkg::RX_IDLE) begin
            rx_cnt_q <= div_eff - 16'h0001;
         end
         unique case (rx_st_q)
            serial_pkg::RX_IDLE: begin
               if (rx_start) begin
                  rx_cnt_q <= div_eff >> 1;                   // Aim at mid-bit
                  rx_bit_q <= 3'h0;
                  rx_st_q  <= sync ? serial_pkg::RX_DATA : serial_pkg::RX_START;
               end
            end
            serial_pkg::RX_START: begin
               if (rx_samp) begin
                  rx_st_q <= rxd_q ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
               end
            end
            serial_pkg::RX_DATA: begin
               if (rx_samp) begin
                  rx_sh_q[rx_bit_q] <= rxd_q;
                  rx_bit_q          <= rx_bit_q + 3'h1;
                  if (rx_bit_q == last_ix) begin
                     rx_st_q <= serial_pkg::RX_STOP;
                  end
               end
            end
            serial_pkg::RX_STOP: begin
               if (rx_samp) begin
                  rx_char_q <= rx_sh_q & mask;
                  rx_pend_q <= 1'b1;
                  rx_st_q   <= serial_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   // Receive FIFO: a read of the data address advances it when it holds a character
   serial_rx_fifo u_rx_fifo (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_flush     (~rx_en),
      .i_in_valid  (rx_pend_q),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (rx_char_q),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (rd_data),
      .o_out_data  (fifo_out_data)
   );

   // Checks on the flags and pins
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_write_full;
      wr_data && txb_full_q && !tx_load;
   endsequence

   property p_drop_write;
      s_write_full |=> (txb_q == $past(txb_q)) && txb_full_q;
   endproperty
   a_drop_write: assert property (p_drop_write)
      else $error("data write taken while buffer full");

   property p_take_write;
      (wr_data && !txb_full_q) |=> !o_udre_irq && txb_full_q && (txb_q == $past(i_io_wdata));
   endproperty
   a_take_write: assert property (p_take_write)
      else $error("data write not taken while buffer empty");

   property p_flush;
      !rx_en |=> !fifo_out_valid && !o_rxc_irq;
   endproperty
   a_flush: assert property (p_flush)
      else $error("receive buffer not flushed on disable");

   property p_rxc_fill;
      (rx_push && !fifo_out_valid && !rd_data && rx_en) |=> ##0 fifo_out_valid ##1 1'b1;
   endproperty
   a_rxc_fill: assert property (p_rxc_fill)
      else $error("receive complete not raised by new character");

   property p_rx_irq;
      (rx_push && rx_en && !rd_data && !wr_ctl && ctrl_q[`CTL_RXC_IE]) |=> o_rxc_irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq)
      else $error("receive complete request missing");

   property p_txc_rise;
      $rose(txc_q) |-> $past(tx_done) && !$past(txb_full_q);
   endproperty
   a_txc_rise: assert property (p_txc_rise)
      else $error("transmit complete set without idle buffer");

   property p_txc_fall;
      $fell(txc_q) |-> $past(i_txc_irq_ack) || $past(wr_stat && i_io_wdata[`STA_TXC]);
   endproperty
   a_txc_fall: assert property (p_txc_fall)
      else $error("transmit complete cleared without cause");

   property p_txc_ack;
      (i_txc_irq_ack && !txc_set) |=> !txc_q [*1] ##0 !o_txc_irq;
   endproperty
   a_txc_ack: assert property (p_txc_ack)
      else $error("transmit complete kept after service");

   property p_async_pin;
      !sync |-> !o_sck_oe && !sck_rise && !sck_fall;
   endproperty
   a_async_pin: assert property (p_async_pin)
      else $error("clock pin active in asynchronous mode");

   property p_master_pin;
      (master && tick) |-> o_sck_oe ##1 (o_sck_o != $past(o_sck_o));
   endproperty
   a_master_pin: assert property (p_master_pin)
      else $error("master clock pin not toggling");
endmodule

// ### core/serial_defines.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 serial transceiver core. Assumes it is included by its bare name by every
 file that uses it and that nothing else defines macros of the same names.
*/
`ifndef SERIAL_DEFINES_SVH
`define SERIAL_DEFINES_SVH

// Register offsets on the I/O access port
`define ADDR_DATA       2'h0
`define ADDR_STAT_A     2'h1
`define ADDR_CTRL       2'h2

// Status A field positions
`define STA_RXC         3'h7
`define STA_TXC         3'h6
`define STA_UDRE        3'h5
`define STA_U2X         3'h1
`define STA_MPCM        3'h0

// Control field positions
`define CTL_RX_EN       3'h0
`define CTL_TX_EN       3'h1
`define CTL_SYNC_SEL    3'h2
`define CTL_SIZE_LO     3'h3
`define CTL_RXC_IE      3'h5
`define CTL_TXC_IE      3'h6
`define CTL_UDRE_IE     3'h7

// Reset values
`define CTRL_RESET      8'h00
`define DATA_RESET      8'h00

// Bit period in clock cycles at normal speed
`define BAUD_DIV_DEFAULT 16'h1046

`endif

// ### core/serial_pkg.sv
/*
 Types shared by the serial transceiver core: transmitter and receiver
 sequencer states. Assumes nothing of its surroundings.
*/
package serial_pkg;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_START,
      TX_DATA,
      TX_STOP,
      TX_LAST
   } tx_state_e;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } rx_state_e;

endpackage

// ### core/serial_rx_fifo.sv
/*
 Two-entry receive buffer with valid/ready on both sides and a flush.
 Assumes a single clock and that the filler honours o_in_ready.
*/
`timescale 1ns/100ps
module serial_rx_fifo (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_flush,
   // Fill side
   input  wire logic       i_in_valid,
   output logic            o_in_ready,
   input  wire logic [7:0] i_in_data,
   // Drain side
   output logic            o_out_valid,
   input  wire logic       i_out_ready,
   output logic [7:0]      o_out_data
);
   logic [7:0] mem_q [2];
   logic       wr_ptr_q;
   logic       rd_ptr_q;
   logic [1:0] cnt_q;
   wire        push = i_in_valid & o_in_ready;
   wire        pop  = i_out_ready & o_out_valid;

   // Flags and head word straight from storage
   assign o_in_ready  = (cnt_q != 2'h2);
   assign o_out_valid = (cnt_q != 2'h0);
   assign o_out_data  = mem_q[rd_ptr_q];

   // Storage is not reset; only the pointers and count define contents
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
      end
   end

   // Flush beats any access in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q    <= 2'h0;
      end else if (i_flush) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q    <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ### testbench/serial_peer.sv
/*
 Remote serial transceiver model: sends and receives framed characters.
 Assumes the bench calls its tasks and that it shares the core clock.
*/
`timescale 1ns/100ps
module serial_peer (
   // Clock
   input  wire logic i_clk,
   // Serial lines
   input  wire logic i_txd,
   output logic      o_rxd,
   // Clock pin, driven only when clocking a slave-mode core
   output logic      o_sck
);
   // Line idles high between frames; the clock rests low outside frames
   initial o_rxd = 1'b1;
   initial o_sck = 1'b0;

   // Clock a slave-mode core: it shifts on our fall and we sample on the
   // rise, so f[0] is the idle level, then start, data and stop
   task automatic sync_recv(output logic [10:0] f, input int half);
      int i;
      f = 11'h000;
      for (i = 0; i < 11; i++) begin
         o_sck = 1'b1;
         f[i] = i_txd;
         repeat (half) @(negedge i_clk);
         o_sck = 1'b0;
         repeat (half) @(negedge i_clk);
      end
   endtask

   // Start, n data bits LSB first, stop, then gap idle cycles
   task automatic send(input logic [7:0] d, input int n, input int div, input int gap);
      int i;
      for (i = -1; i <= n; i++) begin
         @(negedge i_clk);
         o_rxd = (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
         repeat (div - 1) @(negedge i_clk);
      end
      repeat (gap) @(negedge i_clk);
   endtask

   // Sample mid-bit on the falling edge, away from the line's launch edge;
   // ok stays low on timeout or on a missing stop bit
   task automatic recv(output logic [7:0] d, output logic ok, input int n, input int div);
      int i;
      d = 8'h00;
      ok = 1'b0;
      for (i = 0; i < 2000 && i_txd !== 1'b0; i++) @(negedge i_clk);
      if (i_txd !== 1'b0) return;
      repeat (div / 2) @(negedge i_clk);
      for (i = 0; i < n; i++) begin
         repeat (div) @(negedge i_clk);
         d[i] = i_txd;
      end
      repeat (div) @(negedge i_clk);
      ok = (i_txd === 1'b1);
   endtask
endmodule

// ### testbench/tb_top.sv
/*
 Self-checking bench for the serial core: registers, transmit, receive,
 status flags and clock pin. Assumes the peer model on the serial lines.
*/
`timescale 1ns/100ps
`include "serial_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [1:0] addr = 2'h0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic       sck_dir = 1'b0;
   logic       ack = 1'b0;
   logic [7:0] rdata;
   logic       rxd, txd, rxc_irq, txc_irq, udre_irq, sck_o, sck_oe, ok;
   logic [7:0] d;
   logic       sck_i;
   logic [10:0] f;
   int         err_count = 0;
   int         checked = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Short bit period keeps frames to a few dozen cycles
   serial_core #(.BAUD_DIV(16'h0008)) dut_u (
      .i_clk(clk), .i_rst_n(rst_n), .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd),
      .i_io_wdata(wdata), .o_io_rdata(rdata), .i_sck_dir(sck_dir),
      .o_rxc_irq(rxc_irq), .o_txc_irq(txc_irq), .o_udre_irq(udre_irq),
      .i_txc_irq_ack(ack), .i_rxd(rxd), .o_txd(txd), .i_sck_i(sck_i),
      .o_sck_o(sck_o), .o_sck_oe(sck_oe));

   serial_peer peer_u (.i_clk(clk), .i_txd(txd), .o_rxd(rxd), .o_sck(sck_i));

   // Verdict and end of run
   task automatic summarize();
      if (err_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Plain loads and stores only, never read-modify-write on data
   task automatic bus_wr(input logic [1:0] a, input logic [7:0] v);
      @(negedge clk);
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rd_exp(input logic [1:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      `CHK(rdata, e)
   endtask

   // Polls status; a flag that never shows counts as a failure
   task automatic wait_stat(input logic [7:0] m);
      int n;
      for (n = 0; n < 300; n++) begin
         @(negedge clk);
         addr = `ADDR_STAT_A;
         rd = 1'b1;
         @(negedge clk);
         rd = 1'b0;
         if ((rdata & m) === m) return;
      end
      err_count++;
      summarize();
   endtask

   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      `CHK({txd, sck_oe, rxc_irq, txc_irq, udre_irq}, 5'b10000)
      rd_exp(`ADDR_STAT_A, 8'h20);
      rd_exp(`ADDR_CTRL, 8'h00);
      rd_exp(2'h3, 8'h00);
      bus_wr(`ADDR_STAT_A, 8'hFF);
      rd_exp(`ADDR_STAT_A, 8'h23);
      bus_wr(`ADDR_STAT_A, 8'h00);
      // Two characters queue up; a third write while full must vanish
      bus_wr(`ADDR_CTRL, 8'hDA);
      `CHK(udre_irq, 1'b1)
      fork
         begin
            peer_u.recv(d, ok, 8, 8);
            `CHK({ok, d}, 9'h1A5)
            peer_u.recv(d, ok, 8, 8);
            `CHK({ok, d}, 9'h13C)
            peer_u.recv(d, ok, 8, 8);
            `CHK(ok, 1'b0)
         end
         begin
            bus_wr(`ADDR_DATA, 8'hA5);
            bus_wr(`ADDR_DATA, 8'h3C);
            rd_exp(`ADDR_STAT_A, 8'h00);
            `CHK(udre_irq, 1'b0)
            bus_wr(`ADDR_DATA, 8'h77);
         end
      join
      wait_stat(8'h40);
      rd_exp(`ADDR_STAT_A, 8'h60);
      `CHK(txc_irq, 1'b1)
      bus_wr(`ADDR_STAT_A, 8'h00);
      rd_exp(`ADDR_STAT_A, 8'h60);
      bus_wr(`ADDR_STAT_A, 8'h40);
      rd_exp(`ADDR_STAT_A, 8'h20);
      // Five-bit character at double speed; bit 5 low exposes extra bits
      bus_wr(`ADDR_CTRL, 8'h42);
      bus_wr(`ADDR_STAT_A, 8'h02);
      fork
         peer_u.recv(d, ok, 5, 4);
         bus_wr(`ADDR_DATA, 8'hD5);
      join
      `CHK(d, 8'h15)
      `CHK(ok, 1'b1)
      wait_stat(8'h40);
      `CHK(txc_irq, 1'b1)
      @(negedge clk);
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
      rd_exp(`ADDR_STAT_A, 8'h22);
      // Receive two characters, drain them, then flush and short size
      bus_wr(`ADDR_STAT_A, 8'h00);
      bus_wr(`ADDR_CTRL, 8'h39);
      peer_u.send(8'h81, 8, 8, 0);
      peer_u.send(8'h5A, 8, 8, 8);
      wait_stat(8'h80);
      `CHK(rxc_irq, 1'b1)
      rd_exp(`ADDR_DATA, 8'h81);
      rd_exp(`ADDR_STAT_A, 8'hA0);
      rd_exp(`ADDR_DATA, 8'h5A);
      rd_exp(`ADDR_STAT_A, 8'h20);
      peer_u.send(8'h33, 8, 8, 8);
      wait_stat(8'h80);
      bus_wr(`ADDR_CTRL, 8'h38);
      rd_exp(`ADDR_STAT_A, 8'h20);
      bus_wr(`ADDR_CTRL, 8'h01);
      peer_u.send(8'hEA, 5, 8, 8);
      wait_stat(8'h80);
      rd_exp(`ADDR_DATA, 8'h0A);
      // Slave synchronous transmit, clocked by the peer: idle, start, C3, stop
      bus_wr(`ADDR_CTRL, 8'h1E);
      bus_wr(`ADDR_DATA, 8'hC3);
      peer_u.sync_recv(f, 8);
      `CHK(f, 11'h70D)
      rd_exp(`ADDR_STAT_A, 8'h60);
      // Clock pin: driven only as synchronous master
      bus_wr(`ADDR_CTRL, 8'h04);
      sck_dir = 1'b1;
      @(negedge clk);
      `CHK(sck_oe, 1'b1)
      // One divider period later the master clock pin must have toggled once
      ok = sck_o;
      repeat (8) @(negedge clk);
      `CHK(sck_o, ~ok)
      sck_dir = 1'b0;
      @(negedge clk);
      `CHK(sck_oe, 1'b0)
      bus_wr(`ADDR_CTRL, 8'h00);
      sck_dir = 1'b1;
      @(negedge clk);
      `CHK({sck_oe, sck_o}, 2'b00)
      summarize();
   end
endmodule
